// ### hw/ufs_cfg.svh
// register offsets, field positions and reset values for the fifo status block
`ifndef UFS_CFG_SVH
`define UFS_CFG_SVH
`define UFS_OFF_STATUS   12'h07c
`define UFS_OFF_TXLEVEL  12'h080
`define UFS_OFF_RXLEVEL  12'h084
`define UFS_OFF_IRQ_STAT 12'h088
`define UFS_OFF_IRQ_MASK 12'h08c
`define UFS_BIT_RFF      4
`define UFS_BIT_RX_NONEMPTY_FLAG     3
`define UFS_BIT_TFE      2
`define UFS_BIT_TX_SPACE_FLAG     1
`define UFS_BIT_BUSY     0
`define UFS_LVL_MSB      3
`define UFS_STAT_MSB     4
`define UFS_MASK_RST     5'h00
`define UFS_STAT_RST     5'h06
`define UFS_DEPTH_DEF    8
`endif

// ### hw/ufs_pkg.sv
// types shared by the fifo status block
package ufs_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ufs_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ufs_apb_rsp_s;

  typedef struct packed {
    logic rx_full_flag;
    logic rx_nonempty_flag;
    logic tx_empty_flag;
    logic tx_space_flag;
    logic busy;
  } ufs_flags_s;
endpackage

// ### hw/ufs_level.sv
// occupancy counter of one fifo with full and empty flags
`timescale 1ns/1ps
`include "ufs_cfg.svh"
module ufs_level #(
  parameter int DEPTH = `UFS_DEPTH_DEF,
  parameter int CW    = 4
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          push,
  input  wire logic          pop,
  output logic      [CW-1:0] count,
  output logic               full,
  output logic               empty
);
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;

  initial begin
    if (DEPTH < 1 || DEPTH >= (1 << CW)) $error("ufs_level: depth does not fit counter");
  end

  // next count: push on a full fifo or pop on an empty one is dropped
  always_comb begin
    count_next = count_reg;
    if (push && !pop && count_reg != CW'(DEPTH)) begin
      count_next = count_reg + CW'(1);
    end else if (pop && !push && count_reg != '0) begin
      count_next = count_reg - CW'(1);
    end else if (pop && push && count_reg == '0) begin
      count_next = count_reg + CW'(1);
    end
  end

  // occupancy register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
  assign full  = (count_reg == CW'(DEPTH));
  assign empty = (count_reg == '0);
endmodule

// ### hw/ufs_sync.sv
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module ufs_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  // next values of the two stages
  always_comb begin
    meta_next = din;
    sync_next = meta_reg;
  end

  // synchroniser stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg;
endmodule

// ### hw/ufs_top.sv
// uart fifo status and level registers behind an apb slave
//
// Summary of operation
// R1: status bit 4 high while rx fifo full
// R2: status bit 3 high while rx fifo holds data
// R3: status bit 2 high while tx fifo empty
// R4: status bit 1 high while tx fifo has space
// R5: status bit 0 high during serial transfer
// R6: tx level register bits 3:0 give tx count
// R7: rx level register bits 3:0 give rx count
// R8: reserved upper bits read zero, software ignores them
// R9: writes to status and levels change nothing
// R10: flags and counts follow occupancy every cycle
`timescale 1ns/1ps
`include "ufs_cfg.svh"
module ufs_top
  import ufs_pkg::*;
#(
  parameter int DEPTH = `UFS_DEPTH_DEF
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire ufs_pkg::ufs_apb_req_s apb_req,
  output ufs_pkg::ufs_apb_rsp_s      apb_rsp,
  input  wire logic                  tx_push,
  input  wire logic                  tx_pop,
  input  wire logic                  rx_push,
  input  wire logic                  rx_pop,
  input  wire logic                  line_active,
  output ufs_pkg::ufs_flags_s        flags,
  output logic                       irq
);
  import ufs_pkg::*;

  localparam int CW = `UFS_LVL_MSB + 1;
  localparam int SW = `UFS_STAT_MSB + 1;

  initial begin
    if (DEPTH < 1 || DEPTH > 15) $error("ufs_top: depth must be 1 to 15");
  end

  logic [CW-1:0] tx_entry_count;
  logic [CW-1:0] rx_entry_count;
  logic          tx_full;
  logic          tx_empty;
  logic          rx_full;
  logic          rx_empty;
  logic          busy_sync;
  logic [SW-1:0] status_now;
  logic [SW-1:0] status_prev_reg;
  logic [SW-1:0] status_prev_next;
  logic [SW-1:0] irq_stat_reg;
  logic [SW-1:0] irq_stat_next;
  logic [SW-1:0] irq_mask_reg;
  logic [SW-1:0] irq_mask_next;
  logic [31:0]   rdata_reg;
  logic [31:0]   rdata_next;
  logic          err_reg;
  logic          err_next;
  logic          setup;
  logic          wr_en;
  logic          rd_stat_clr;

  // returns 1 when the address is one of the mapped words
  function automatic logic ufs_hit(input logic [11:0] a);
    ufs_hit = (a == `UFS_OFF_STATUS) || (a == `UFS_OFF_TXLEVEL) ||
              (a == `UFS_OFF_RXLEVEL) || (a == `UFS_OFF_IRQ_STAT) ||
              (a == `UFS_OFF_IRQ_MASK);
  endfunction

  // transmit fifo occupancy
  ufs_level #(.DEPTH(DEPTH), .CW(CW)) u_tx_level (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (tx_push),
    .pop     (tx_pop),
    .count   (tx_entry_count),
    .full    (tx_full),
    .empty   (tx_empty)
  );

  // receive fifo occupancy
  ufs_level #(.DEPTH(DEPTH), .CW(CW)) u_rx_level (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (rx_push),
    .pop     (rx_pop),
    .count   (rx_entry_count),
    .full    (rx_full),
    .empty   (rx_empty)
  );

  // line activity comes from the shifter clock side
  ufs_sync u_busy_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (line_active),
    .dout    (busy_sync)
  );

  // live status word straight from the counters, bit 0 from the busy synchroniser
  always_comb begin
    status_now                 = '0;
    status_now[`UFS_BIT_RFF]   = rx_full;   // [R1]
    status_now[`UFS_BIT_RX_NONEMPTY_FLAG]  = !rx_empty; // [R2]
    status_now[`UFS_BIT_TFE]   = tx_empty;  // [R3]
    status_now[`UFS_BIT_TX_SPACE_FLAG]  = !tx_full;  // [R4]
    status_now[`UFS_BIT_BUSY]  = busy_sync; // [R5]
  end

  assign flags.rx_full_flag     = status_now[`UFS_BIT_RFF];
  assign flags.rx_nonempty_flag = status_now[`UFS_BIT_RX_NONEMPTY_FLAG];
  assign flags.tx_empty_flag    = status_now[`UFS_BIT_TFE];
  assign flags.tx_space_flag    = status_now[`UFS_BIT_TX_SPACE_FLAG];
  assign flags.busy             = status_now[`UFS_BIT_BUSY];

  // apb decode; slave answers in the first access cycle
  assign setup       = apb_req.psel && !apb_req.penable;
  assign wr_en       = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_stat_clr = apb_req.psel && apb_req.penable && !apb_req.pwrite &&
                       apb_req.paddr == `UFS_OFF_IRQ_STAT;

  // read data, error and register updates
  always_comb begin
    rdata_next       = rdata_reg;
    err_next         = err_reg;
    irq_mask_next    = irq_mask_reg;
    status_prev_next = status_now;
    // events are rising edges of each status bit; set wins over read clear
    irq_stat_next    = (rd_stat_clr ? '0 : irq_stat_reg) |
                       (status_now & ~status_prev_reg);
    if (setup) begin
      err_next   = !ufs_hit(apb_req.paddr);
      rdata_next = '0; // [R8]
      if (!apb_req.pwrite) begin
        case (apb_req.paddr)
          `UFS_OFF_STATUS:   rdata_next[SW-1:0] = status_now;     // [R10]
          `UFS_OFF_TXLEVEL:  rdata_next[CW-1:0] = tx_entry_count; // [R6]
          `UFS_OFF_RXLEVEL:  rdata_next[CW-1:0] = rx_entry_count; // [R7]
          `UFS_OFF_IRQ_STAT: rdata_next[SW-1:0] = irq_stat_reg;
          `UFS_OFF_IRQ_MASK: rdata_next[SW-1:0] = irq_mask_reg;
          default:           rdata_next         = '0;
        endcase
      end
    end
    // only the mask takes writes; status and levels ignore them
    if (wr_en && apb_req.paddr == `UFS_OFF_IRQ_MASK) begin // [R9]
      irq_mask_next = apb_req.pwdata[SW-1:0];
    end
  end

  // register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg       <= '0;
      err_reg         <= 1'b0;
      irq_mask_reg    <= `UFS_MASK_RST;
      irq_stat_reg    <= '0;
      status_prev_reg <= `UFS_STAT_RST;
    end else begin
      rdata_reg       <= rdata_next;
      err_reg         <= err_next;
      irq_mask_reg    <= irq_mask_next;
      irq_stat_reg    <= irq_stat_next;
      status_prev_reg <= status_prev_next;
    end
  end

  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = err_reg && apb_req.psel && apb_req.penable;
  assign apb_rsp.prdata  = rdata_reg;
  assign irq             = |(irq_stat_reg & irq_mask_reg);
endmodule

// ### dv/ufs_chk.sv
// concurrent checks on the fifo status block ports
`timescale 1ns/1ps
module ufs_chk
  import ufs_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire ufs_pkg::ufs_apb_req_s apb_req,
  input wire ufs_pkg::ufs_apb_rsp_s apb_rsp,
  input wire logic                  tx_push,
  input wire logic                  tx_pop,
  input wire logic                  rx_push,
  input wire logic                  rx_pop,
  input wire logic                  line_active,
  input wire ufs_pkg::ufs_flags_s   flags
);
  logic [4:0] tx_reg;
  logic [4:0] tx_next;
  logic [4:0] rx_reg;
  logic [4:0] rx_next;
  logic       rd;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // reference occupancy; push on full dropped unless a pop frees room, empty pop dropped
  always_comb begin
    tx_next = tx_reg + 5'(tx_push && (tx_reg != DEPTH || tx_pop))
                     - 5'(tx_pop && tx_reg != 0);
    rx_next = rx_reg + 5'(rx_push && (rx_reg != DEPTH || rx_pop))
                     - 5'(rx_pop && rx_reg != 0);
  end
  // register reference counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_reg <= 5'h00;
      rx_reg <= 5'h00;
    end else begin
      tx_reg <= tx_next;
      rx_reg <= rx_next;
    end
  end
  assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  a_rx_full: assert property (flags.rx_full_flag == (rx_reg == DEPTH))
    else $error("rx full flag wrong");
  a_rx_nonempty: assert property (flags.rx_nonempty_flag == (rx_reg != 0))
    else $error("rx nonempty flag wrong");
  a_tx_empty: assert property (flags.tx_empty_flag == (tx_reg == 0))
    else $error("tx empty flag wrong");
  a_tx_space: assert property (flags.tx_space_flag == (tx_reg != DEPTH))
    else $error("tx space flag wrong");
  a_busy_follow: assert property (line_active [*3] |-> flags.busy)
    else $error("busy not raised");
  a_tx_level: assert property (rd && apb_req.paddr == 12'h080
    |-> apb_rsp.prdata == {27'h0, $past(tx_reg)}) else $error("tx level read wrong");
  a_rx_level: assert property (rd && apb_req.paddr == 12'h084
    |-> apb_rsp.prdata == {27'h0, $past(rx_reg)}) else $error("rx level read wrong");
  a_stat_upper: assert property (rd && apb_req.paddr == 12'h07c
    |-> apb_rsp.prdata[31:5] == 27'h0) else $error("status upper bits set");
  c_rx_full: cover property (flags.rx_full_flag);
  c_tx_full: cover property (!flags.tx_space_flag);
  c_busy: cover property (flags.busy);
endmodule

bind ufs_top ufs_chk #(.DEPTH(DEPTH)) u_chk (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .tx_push(tx_push), .tx_pop(tx_pop), .rx_push(rx_push), .rx_pop(rx_pop),
  .line_active(line_active), .flags(flags)
);

// ### dv/ufs_far_end.sv
// remote serial device: one character per send, then a received entry
`timescale 1ns/1ps
module ufs_far_end #(
  parameter int CHAR = 12
) (
  input wire logic pclk,
  input wire logic send,
  output logic     line_active,
  output logic     rx_push
);
  int n = 0;
  initial rx_push = 1'b0;
  // character timer, entry pushed as the character ends
  always @(posedge pclk) begin
    rx_push <= 1'b0;
    if (send) begin
      n <= CHAR;
    end else if (n > 0) begin
      n <= n - 1;
      rx_push <= (n == 1);
    end
  end
  assign line_active = (n > 0);
endmodule

// ### dv/tb_top.sv
// self-checking bench of the fifo status block
`timescale 1ns/1ps
module tb_top;
  import ufs_pkg::*;
  localparam int D = 4;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  ufs_apb_req_s req = '0;
  ufs_apb_rsp_s rsp;
  ufs_flags_s   flags;
  logic [3:0]   ev = 4'h0;
  logic         send = 1'b0;
  logic         far_push;
  logic         line_active;
  logic         irq;
  logic         err;
  logic [31:0]  rdat;
  int           fails = 0;
  int           comparisons = 0;
  int           cyc = 0;
  always #2.5 pclk = ~pclk;
  ufs_far_end #(.CHAR(12)) u_far (.pclk(pclk), .send(send), .line_active(line_active),
    .rx_push(far_push));
  ufs_top #(.DEPTH(D)) u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .tx_push(ev[3]), .tx_pop(ev[2]), .rx_push(ev[1] | far_push), .rx_pop(ev[0]),
    .line_active(line_active), .flags(flags), .irq(irq));
  task give_verdict;
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer: setup, access until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk) req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input string nm, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  // n one-cycle fifo event pulses
  task go(input logic [3:0] e, input int n);
    repeat (n) begin
      @(posedge pclk) ev <= e;
      @(posedge pclk) ev <= 4'h0;
    end
  endtask
  // cycle ceiling against hangs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      give_verdict;
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h07c, "status", 32'h6);
    rd(12'h080, "tx_level", 32'h0);
    rd(12'h084, "rx_level", 32'h0);
    rd(12'h000, "unmapped", 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    go(4'h8, D + 1);
    rd(12'h080, "tx_level", D);
    rd(12'h07c, "status", 32'h0);
    apb(1'b1, 12'h07c, 32'hffff_ffff);
    apb(1'b1, 12'h080, 32'hffff_ffff);
    rd(12'h080, "tx_level", D);
    go(4'h4, D);
    rd(12'h07c, "status", 32'h6);
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge pclk) send <= 1'b1;
    @(posedge pclk) send <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(12'h07c, "status", 32'h7);
    repeat (20) @(posedge pclk);
    rd(12'h084, "rx_level", 32'h1);
    rd(12'h07c, "status", 32'he);
    apb(1'b0, 12'h088, 32'h0);
    apb(1'b1, 12'h08c, 32'h10);
    go(4'h2, D - 1);
    rd(12'h07c, "status", 32'h1e);
    chk("irq", 32'h1, {31'h0, irq});
    rd(12'h088, "irq_stat", 32'h10);
    @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    go(4'h1, 1);
    rd(12'h07c, "status", 32'he);
    rd(12'h084, "rx_level", D - 1);
    give_verdict;
  end
endmodule
